// File: legacy_driver_support_logic.sv
// Support logic for the older current-word stepper driver family
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns

// Summary of operation
// - Copy eight driver flags into status 31:24
// - Send word only when coarse current or idle bit changes
// - Each coil: four-bit magnitude plus polarity
// - Resolution finer than 16 leaves word unchanged
// - Fullstep currents above threshold velocity
// - Return to microstep below threshold
// - Fullstep flag while enabled and engaged
// - Two-bit decay setting selects mixed-decay policy
// - Decay bits from setting and table position
// - Pin code 10 outputs divided chopper clock
// - Reset default outputs undivided system clock
// - Standstill doubling halves divider when enabled, decay code not 00
// - Load value 0..7, lower means heavier
// - Stall when load at or below limit
// - Stall above velocity limit zeroes ramp velocity
// - Idle option zeroes currents, sends idle word
// - Swap option shows stall in status bit 24
// - Masked driver flags OR into motor event
// - Format codes 1000 or 1001 enable logic
module legacy_driver_support_logic (
	input  wire logic                              sys_clk,
	input  wire logic                              rst,
	input  wire logic                              clk_en,
	input  wire logic [3:0]                        reg_addr,
	input  wire logic [31:0]                       reg_wdata,
	input  wire logic                              reg_write,
	input  wire logic                              reg_read,
	output logic      [31:0]                       reg_rdata,
	input  wire logic [31:0]                       actual_ramp_velocity,
	input  wire logic [8:0]                        coil_a_current,
	input  wire logic [8:0]                        coil_b_current,
	input  wire logic [8:0]                        coil_a_fullstep,
	input  wire logic [8:0]                        coil_b_fullstep,
	input  wire logic [7:0]                        sine_lookup_table_pos,
	input  wire logic                              response_valid,
	input  wire legacy_driver_pkg::response_s      response,
	output legacy_driver_pkg::current_word_s       word_data,
	output logic                                   word_send,
	output logic                                   ramp_velocity_zero,
	output logic                                   motor_event,
	output logic                                   driver_clock_out
);

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] global_config_reg;
	logic [31:0] reference_config_reg;
	logic [31:0] driver_link_config_reg;
	logic [31:0] motor_flag_event_mask_reg;
	logic [31:0] fullstep_velocity_threshold_reg;
	logic [15:0] chopper_clock_divider_reg;
	logic [31:0] min_velocity_for_stall_reg;
	logic [7:0]  flags_reg;
	logic        stall_reg;
	logic        active_stall_reg;
	logic        fullstep_engaged_flag;
	legacy_driver_pkg::run_state_e state_reg;
	legacy_driver_pkg::current_word_s last_word_reg;
	logic        word_pending_reg;
	logic [15:0] div_count_reg;
	logic        div_clk_reg;

	// ****************************************
	// Configuration fields and derived signals
	// ****************************************
	logic        enabled;
	logic [1:0]  decay_mode;
	logic [31:0] abs_velocity;
	logic        moving;
	logic        stall_now;
	logic        stall_stop;
	logic [15:0] div_eff;
	logic [7:0]  status_flags;
	logic [31:0] status_word;
	logic [8:0]  cur_a;
	logic [8:0]  cur_b;
	legacy_driver_pkg::current_word_s new_word;

	// Either legacy format code turns the block on
	assign enabled = (driver_link_config_reg[legacy_driver_pkg::FORMAT_LSB +: 4] == legacy_driver_pkg::FORMAT_VARIANT_A)
		|| (driver_link_config_reg[legacy_driver_pkg::FORMAT_LSB +: 4] == legacy_driver_pkg::FORMAT_VARIANT_B);
	assign decay_mode   = driver_link_config_reg[legacy_driver_pkg::MIXED_DECAY_LSB +: 2];
	assign abs_velocity = actual_ramp_velocity[31] ? (~actual_ramp_velocity + 32'h0000_0001) : actual_ramp_velocity;
	assign moving       = (abs_velocity != 32'h0000_0000);

	// ****************************************
	// Register write port
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			global_config_reg               <= legacy_driver_pkg::RESET_ZERO;
			reference_config_reg            <= legacy_driver_pkg::RESET_ZERO;
			driver_link_config_reg          <= legacy_driver_pkg::RESET_ZERO;
			motor_flag_event_mask_reg       <= legacy_driver_pkg::RESET_ZERO;
			fullstep_velocity_threshold_reg <= legacy_driver_pkg::RESET_ZERO;
			chopper_clock_divider_reg       <= legacy_driver_pkg::RESET_CHOP_DIV;
			min_velocity_for_stall_reg      <= legacy_driver_pkg::RESET_ZERO;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
				legacy_driver_pkg::ADDR_GLOBAL_CONFIG:      global_config_reg <= reg_wdata;
				legacy_driver_pkg::ADDR_REFERENCE_CONFIG:   reference_config_reg <= reg_wdata;
				legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG: driver_link_config_reg <= reg_wdata;
				legacy_driver_pkg::ADDR_MOTOR_EVENT_MASK:   motor_flag_event_mask_reg <= reg_wdata;
				legacy_driver_pkg::ADDR_FULLSTEP_VEL:       fullstep_velocity_threshold_reg <= reg_wdata;
				legacy_driver_pkg::ADDR_CHOPPER_DIV:        chopper_clock_divider_reg <= reg_wdata[15:0];
				legacy_driver_pkg::ADDR_STALL_VEL:          min_velocity_for_stall_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Status composition; swap option puts stall on the lowest flag
	always_comb begin
		status_flags = flags_reg;
		if (driver_link_config_reg[legacy_driver_pkg::SWAP_FLAG_BIT]) begin
			status_flags[0] = stall_reg;
		end
		status_word = 32'h0000_0000;
		status_word[legacy_driver_pkg::STATUS_FLAGS_LSB +: 8] = status_flags;
		status_word[legacy_driver_pkg::STATUS_FS_BIT]     = fullstep_engaged_flag;
		status_word[legacy_driver_pkg::STATUS_STALL_BIT]  = stall_reg;
		status_word[legacy_driver_pkg::STATUS_ACTIVE_BIT] = active_stall_reg;
	end

	// ****************************************
	// Register read port, data one cycle later
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (reg_read) begin
				case (reg_addr)
					legacy_driver_pkg::ADDR_GLOBAL_CONFIG:      reg_rdata <= global_config_reg;
					legacy_driver_pkg::ADDR_REFERENCE_CONFIG:   reg_rdata <= reference_config_reg;
					legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG: reg_rdata <= driver_link_config_reg;
					legacy_driver_pkg::ADDR_MOTOR_EVENT_MASK:   reg_rdata <= motor_flag_event_mask_reg;
					legacy_driver_pkg::ADDR_STATUS:             reg_rdata <= status_word;
					legacy_driver_pkg::ADDR_FULLSTEP_VEL:       reg_rdata <= fullstep_velocity_threshold_reg;
					legacy_driver_pkg::ADDR_CHOPPER_DIV:        reg_rdata <= {16'h0000, chopper_clock_divider_reg};
					legacy_driver_pkg::ADDR_STALL_VEL:          reg_rdata <= min_velocity_for_stall_reg;
					default:                                    reg_rdata <= 32'h0000_0000;
				endcase
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Response capture and stall detection
	// ****************************************
	// Load compared unsigned: lower load value means heavier load
	assign stall_now = (response.load <= driver_link_config_reg[legacy_driver_pkg::STALL_LIMIT_LSB +: 3]);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags_reg <= 8'h00;
			stall_reg <= 1'b0;
		end else if (clk_en && response_valid && enabled) begin
			flags_reg <= response.flags;
			stall_reg <= stall_now;
		end
	end

	// Masked flags form the motor event as an OR, registered one cycle later
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			motor_event <= 1'b0;
		end else if (clk_en) begin
			motor_event <= |(status_flags & motor_flag_event_mask_reg[legacy_driver_pkg::MASK_LSB +: 8]);
		end
	end

	// ****************************************
	// Stepping mode and stop on stall
	// ****************************************
	assign stall_stop = stall_reg && (abs_velocity > min_velocity_for_stall_reg)
		&& reference_config_reg[legacy_driver_pkg::STOP_ON_STALL_BIT]
		&& !reference_config_reg[legacy_driver_pkg::DRIVE_AFTER_BIT];

	// Block is held until software sets drive-after-stall; no self release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= legacy_driver_pkg::RUN_MICRO;
		end else if (clk_en) begin
			case (state_reg)
				legacy_driver_pkg::RUN_MICRO: begin
					if (stall_stop) begin
						state_reg <= legacy_driver_pkg::RUN_BLOCK;
					end else if (global_config_reg[legacy_driver_pkg::FULLSTEP_SWITCH_ENABLE_BIT]
						&& abs_velocity > fullstep_velocity_threshold_reg) begin
						state_reg <= legacy_driver_pkg::RUN_FULL;
					end
				end
				legacy_driver_pkg::RUN_FULL: begin
					if (stall_stop) begin
						state_reg <= legacy_driver_pkg::RUN_BLOCK;
					end else if (!global_config_reg[legacy_driver_pkg::FULLSTEP_SWITCH_ENABLE_BIT]
						|| abs_velocity < fullstep_velocity_threshold_reg) begin
						state_reg <= legacy_driver_pkg::RUN_MICRO;
					end
				end
				legacy_driver_pkg::RUN_BLOCK: begin
					if (reference_config_reg[legacy_driver_pkg::DRIVE_AFTER_BIT]) begin
						state_reg <= legacy_driver_pkg::RUN_MICRO;
					end
				end
				default: state_reg <= legacy_driver_pkg::RUN_MICRO;
			endcase
		end
	end

	assign fullstep_engaged_flag = (state_reg == legacy_driver_pkg::RUN_FULL)
		&& global_config_reg[legacy_driver_pkg::FULLSTEP_SWITCH_ENABLE_BIT];
	assign ramp_velocity_zero = (state_reg == legacy_driver_pkg::RUN_BLOCK) || stall_stop;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			active_stall_reg <= 1'b0;
		end else if (clk_en) begin
			active_stall_reg <= stall_stop;
		end
	end

	// ****************************************
	// Current word build and change filter
	// ****************************************
	// Only coarse bits reach the word, so finer resolutions never resend
	always_comb begin
		cur_a = fullstep_engaged_flag ? coil_a_fullstep : coil_a_current;
		cur_b = fullstep_engaged_flag ? coil_b_fullstep : coil_b_current;
		new_word = '0;
		new_word.pol_a = cur_a[8];
		new_word.mag_a = cur_a[7:4];
		new_word.pol_b = cur_b[8];
		new_word.mag_b = cur_b[7:4];
		// Falling slope: coil a in the second half of each table half (position bit 6 set), coil b in the first half
		case (decay_mode)
			legacy_driver_pkg::DECAY_NEVER: begin
				new_word.decay_a = 1'b0;
				new_word.decay_b = 1'b0;
			end
			legacy_driver_pkg::DECAY_FALLING: begin
				new_word.decay_a = sine_lookup_table_pos[6];
				new_word.decay_b = ~sine_lookup_table_pos[6];
			end
			legacy_driver_pkg::DECAY_MOVING: begin
				new_word.decay_a = moving;
				new_word.decay_b = moving;
			end
			default: begin
				new_word.decay_a = 1'b1;
				new_word.decay_b = 1'b1;
			end
		endcase
		if (state_reg == legacy_driver_pkg::RUN_BLOCK
			&& driver_link_config_reg[legacy_driver_pkg::IDLE_WORD_BIT]) begin
			new_word = '0;
			new_word.idle = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_word_reg    <= '0;
			word_data        <= '0;
			word_pending_reg <= 1'b0;
		end else if (clk_en) begin
			word_pending_reg <= 1'b0;
			if (enabled && (new_word.mag_a != last_word_reg.mag_a || new_word.pol_a != last_word_reg.pol_a
				|| new_word.mag_b != last_word_reg.mag_b || new_word.pol_b != last_word_reg.pol_b
				|| new_word.idle != last_word_reg.idle)) begin
				last_word_reg    <= new_word;
				word_data        <= new_word;
				word_pending_reg <= 1'b1;
			end
		end
	end
	assign word_send = word_pending_reg;

	// ****************************************
	// Chopper clock output
	// ****************************************
	// Idle doubling halves the divider; an effective divider below two holds the output high
	assign div_eff = (driver_link_config_reg[legacy_driver_pkg::DOUBLE_RATE_BIT]
		&& decay_mode != legacy_driver_pkg::DECAY_NEVER && !moving)
		? {1'b0, chopper_clock_divider_reg[15:1]} : chopper_clock_divider_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_count_reg <= 16'h0000;
			div_clk_reg   <= 1'b0;
		end else if (clk_en) begin
			if (div_count_reg + 16'h0001 >= div_eff) begin
				div_count_reg <= 16'h0000;
				div_clk_reg   <= 1'b1;
			end else begin
				div_count_reg <= div_count_reg + 16'h0001;
				if (div_count_reg + 16'h0001 >= {1'b0, div_eff[15:1]}) begin
					div_clk_reg <= 1'b0;
				end
			end
		end
	end

	// Default pin code after reset forwards the system clock itself
	assign driver_clock_out = (global_config_reg[legacy_driver_pkg::CLK_PIN_LSB +: 2] == legacy_driver_pkg::CLK_PIN_CHOPPER)
		? div_clk_reg : sys_clk;

	// ****************************************
	// Assertions
	// ****************************************
	property p_stall_cmp;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && response_valid && enabled) |=> (stall_reg == ($past(response.load) <= $past(driver_link_config_reg[10:8])));
	endproperty
	a_stall_cmp: assert property (p_stall_cmp) else $error("stall flag mismatch");

	property p_flags;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && response_valid && enabled) |=> (flags_reg == $past(response.flags));
	endproperty
	a_flags: assert property (p_flags) else $error("flags not captured");

	property p_zero_vel;
		@(posedge sys_clk) disable iff (rst)
		stall_stop |-> ramp_velocity_zero;
	endproperty
	a_zero_vel: assert property (p_zero_vel) else $error("ramp not stopped");

	property p_block_hold;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && state_reg == legacy_driver_pkg::RUN_BLOCK && !reference_config_reg[27]) |=> state_reg == legacy_driver_pkg::RUN_BLOCK;
	endproperty
	a_block_hold: assert property (p_block_hold) else $error("block released");

	property p_send_change;
		@(posedge sys_clk) disable iff (rst)
		word_send |-> (word_data != $past(word_data) || $past(word_data) == '0);
	endproperty
	a_send_change: assert property (p_send_change) else $error("word resent unchanged");

	property p_fs_flag;
		@(posedge sys_clk) disable iff (rst)
		fullstep_engaged_flag |-> global_config_reg[19];
	endproperty
	a_fs_flag: assert property (p_fs_flag) else $error("fullstep flag without enable");

	property p_equal_keep;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && !stall_stop && abs_velocity == fullstep_velocity_threshold_reg && global_config_reg[19]
			&& state_reg != legacy_driver_pkg::RUN_BLOCK) |=> $stable(state_reg);
	endproperty
	a_equal_keep: assert property (p_equal_keep) else $error("mode toggled at equality");

	property p_event;
		@(posedge sys_clk) disable iff (rst)
		clk_en |=> motor_event == |($past(status_flags) & $past(motor_flag_event_mask_reg[23:16]));
	endproperty
	a_event: assert property (p_event) else $error("motor event mismatch");

	c_stall: cover property (@(posedge sys_clk) disable iff (rst) stall_stop);
	c_full: cover property (@(posedge sys_clk) disable iff (rst) state_reg == legacy_driver_pkg::RUN_FULL);
	c_send: cover property (@(posedge sys_clk) disable iff (rst) word_send && word_data.idle);

endmodule

// File: legacy_driver_pkg.sv
// Package: constants and carriers for the legacy driver support logic
package legacy_driver_pkg;

	// ****************************************
	// Register map (plain port, word index)
	// ****************************************
	localparam logic [3:0] ADDR_GLOBAL_CONFIG      = 4'h0;
	localparam logic [3:0] ADDR_REFERENCE_CONFIG   = 4'h1;
	localparam logic [3:0] ADDR_DRIVER_LINK_CONFIG = 4'h4;
	localparam logic [3:0] ADDR_MOTOR_EVENT_MASK   = 4'h5;
	localparam logic [3:0] ADDR_STATUS             = 4'h6;
	localparam logic [3:0] ADDR_FULLSTEP_VEL       = 4'h7;
	localparam logic [3:0] ADDR_CHOPPER_DIV        = 4'h8;
	localparam logic [3:0] ADDR_STALL_VEL          = 4'h9;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int FULLSTEP_SWITCH_ENABLE_BIT          = 19;
	localparam int CLK_PIN_LSB        = 14;
	localparam int STOP_ON_STALL_BIT  = 26;
	localparam int DRIVE_AFTER_BIT    = 27;
	localparam int FORMAT_LSB         = 0;
	localparam int IDLE_WORD_BIT      = 6;
	localparam int STALL_LIMIT_LSB    = 8;
	localparam int DOUBLE_RATE_BIT    = 20;
	localparam int SWAP_FLAG_BIT      = 21;
	localparam int MIXED_DECAY_LSB    = 22;
	localparam int MASK_LSB           = 16;
	localparam int STATUS_FLAGS_LSB   = 24;
	localparam int STATUS_FS_BIT      = 0;
	localparam int STATUS_STALL_BIT   = 1;
	localparam int STATUS_ACTIVE_BIT  = 2;

	// ****************************************
	// Codes and reset values
	// ****************************************
	localparam logic [3:0]  FORMAT_VARIANT_A = 4'h8;
	localparam logic [3:0]  FORMAT_VARIANT_B = 4'h9;
	localparam logic [1:0]  CLK_PIN_CHOPPER  = 2'h2;
	localparam logic [1:0]  DECAY_NEVER      = 2'h0;
	localparam logic [1:0]  DECAY_FALLING    = 2'h1;
	localparam logic [1:0]  DECAY_MOVING     = 2'h2;
	localparam logic [1:0]  DECAY_ALWAYS     = 2'h3;
	localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;
	localparam logic [15:0] RESET_CHOP_DIV   = 16'h0010;

	// Outgoing current word fields
	typedef struct packed {
		logic       idle;
		logic       decay_b;
		logic       pol_b;
		logic [3:0] mag_b;
		logic       decay_a;
		logic       pol_a;
		logic [3:0] mag_a;
	} current_word_s;

	// Response flags from the driver
	typedef struct packed {
		logic [2:0] load;
		logic [7:0] flags;
	} response_s;

	typedef enum logic [2:0] {
		RUN_MICRO = 3'b001,
		RUN_FULL  = 3'b010,
		RUN_BLOCK = 3'b100
	} run_state_e;

endpackage

// File: legacy_driver_partner.sv
// Partner model: legacy stepper driver answering each current word with status
`timescale 1ns/1ns
module legacy_driver_partner (
	input  wire logic                         sys_clk,
	input  wire logic                         word_send,
	input  wire logic [7:0]                   flags_cfg,
	input  wire logic [2:0]                   load_cfg,
	output logic                              response_valid,
	output legacy_driver_pkg::response_s      response
);
	logic [2:0] delay_reg;

	initial begin
		delay_reg = 3'h0;
		response_valid = 1'b0;
		response = 11'h000;
	end

	// Answer four cycles after each word; between answers the lines toggle so stale data never looks valid
	always @(posedge sys_clk) begin
		delay_reg <= {delay_reg[1:0], word_send};
		response_valid <= delay_reg[2];
		if (delay_reg[2]) begin
			response <= {load_cfg, flags_cfg};
		end else begin
			response <= ~response;
		end
	end
endmodule

// File: legacy_driver_support_logic_bench.sv
// Testbench: registers, current words, stepping mode, decay, clock output and stall stop
`timescale 1ns/1ns
module legacy_driver_support_logic_bench;
	logic                               sys_clk = 1'b0;
	logic                               rst = 1'b1;
	logic                               clk_en = 1'b1;
	logic [5:0][3:0]                    decay_plan = 24'hBF8560; // Per step: decay code, expected decay a and b
	logic [3:0]                         reg_addr = 4'h0;
	logic [31:0]                        reg_wdata = 32'h0000_0000;
	logic                               reg_write = 1'b0;
	logic                               reg_read = 1'b0;
	logic [31:0]                        reg_rdata;
	logic [31:0]                        vel = 32'h0000_0000;
	logic [8:0]                         cur_a = 9'h000;
	logic [8:0]                         cur_b = 9'h000;
	logic [8:0]                         fs_a = 9'h0B0;
	logic [8:0]                         fs_b = 9'h1B0;
	logic [7:0]                         pos = 8'h00;
	logic [7:0]                         flags_cfg = 8'hA5;
	logic [2:0]                         load_cfg = 3'h7;
	logic                               response_valid;
	legacy_driver_pkg::response_s       response;
	legacy_driver_pkg::current_word_s   w;
	logic                               word_send;
	logic                               ramp_velocity_zero;
	logic                               motor_event;
	logic                               driver_clock_out;
	logic [31:0]                        d;
	int                                 r;
	int                                 n_errors = 0;
	int                                 check_count = 0;

	always #25 sys_clk = ~sys_clk;

	legacy_driver_support_logic u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.actual_ramp_velocity(vel), .coil_a_current(cur_a), .coil_b_current(cur_b), .coil_a_fullstep(fs_a),
		.coil_b_fullstep(fs_b), .sine_lookup_table_pos(pos), .response_valid(response_valid),
		.response(response), .word_data(w), .word_send(word_send), .ramp_velocity_zero(ramp_velocity_zero),
		.motor_event(motor_event), .driver_clock_out(driver_clock_out));

	legacy_driver_partner u_partner (.sys_clk(sys_clk), .word_send(word_send), .flags_cfg(flags_cfg),
		.load_cfg(load_cfg), .response_valid(response_valid), .response(response));

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic set_cur(input logic [8:0] a, input logic [8:0] b);
		@(posedge sys_clk);
		cur_a <= a;
		cur_b <= b;
	endtask

	// Bounded wait so a missing word is reported instead of hanging
	task automatic get_word();
		int k;
		k = 0;
		while (k < 30) begin
			@(posedge sys_clk);
			#1 k = (word_send === 1'b1) ? 99 : k + 1;
		end
		chk(32'(k == 99), 32'h0000_0001, "word sent");
	endtask

	task automatic no_word(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1 if (word_send === 1'b1) k++;
		end
		chk(32'(k), 32'h0000_0000, "no word");
	endtask

	task automatic chk_cur(input logic [8:0] a, input logic [8:0] b);
		chk({22'h0, w.pol_a, w.mag_a, w.pol_b, w.mag_b}, {22'h0, a[8:4], b[8:4]}, "currents");
	endtask

	// Settle, then count rising edges of the clock output over n cycles
	task automatic count_rises(input int n, output int cnt);
		logic last;
		cnt = 0;
		repeat (1000) @(posedge sys_clk);
		#1 last = driver_clock_out;
		repeat (n) begin
			@(posedge sys_clk);
			#1 if (driver_clock_out === 1'b1 && last === 1'b0) cnt++;
			last = driver_clock_out;
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well above the few thousand cycles the tests need
	initial begin
		#(20000 * 50);
		n_errors++;
		tally_and_finish();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#5 chk(32'(driver_clock_out), 32'h0000_0001, "clock high");
		@(negedge sys_clk);
		#5 chk(32'(driver_clock_out), 32'h0000_0000, "clock low");
		rd(legacy_driver_pkg::ADDR_CHOPPER_DIV, d);
		chk(d, 32'h0000_0010, "divider reset");
		// A write while the clock enable is low must not land
		@(posedge sys_clk) clk_en <= 1'b0;
		wr(legacy_driver_pkg::ADDR_CHOPPER_DIV, 32'h0000_0055);
		clk_en <= 1'b1;
		rd(legacy_driver_pkg::ADDR_CHOPPER_DIV, d);
		chk(d, 32'h0000_0010, "frozen write");
		wr(legacy_driver_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		rd(legacy_driver_pkg::ADDR_STATUS, d);
		chk(d, 32'h0000_0000, "status read only");
		wr(4'hF, 32'hFFFF_FFFF);
		rd(4'hF, d);
		chk(d, 32'h0000_0000, "unmapped");
		$display("test registers done");
		// Words leave only when enabled and only on coarse changes
		set_cur(9'h1A5, 9'h030);
		no_word(10);
		wr(legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG, 32'h0000_0008);
		get_word();
		chk_cur(9'h1A5, 9'h030);
		set_cur(9'h1AF, 9'h03C);
		no_word(10);
		set_cur(9'h1B0, 9'h03C);
		get_word();
		chk_cur(9'h1B0, 9'h03C);
		rd(legacy_driver_pkg::ADDR_STATUS, d);
		chk({24'h0, d[31:24]}, 32'h0000_00A5, "flags");
		wr(legacy_driver_pkg::ADDR_MOTOR_EVENT_MASK, 32'h0004_0000);
		repeat (3) @(posedge sys_clk);
		#1 chk(32'(motor_event), 32'h0000_0001, "event set");
		wr(legacy_driver_pkg::ADDR_MOTOR_EVENT_MASK, 32'h0002_0000);
		repeat (3) @(posedge sys_clk);
		#1 chk(32'(motor_event), 32'h0000_0000, "event masked");
		$display("test words done");
		// Stepping mode switch, with hold at equality and absolute velocity
		wr(legacy_driver_pkg::ADDR_FULLSTEP_VEL, 32'h0000_0064);
		wr(legacy_driver_pkg::ADDR_GLOBAL_CONFIG, 32'h0008_0000);
		@(posedge sys_clk) vel <= 32'h0000_00C8;
		get_word();
		chk_cur(fs_a, fs_b);
		rd(legacy_driver_pkg::ADDR_STATUS, d);
		chk(32'(d[0]), 32'h0000_0001, "fullstep flag");
		@(posedge sys_clk) vel <= 32'h0000_0064;
		no_word(8);
		@(posedge sys_clk) vel <= 32'hFFFF_FFCE;
		get_word();
		chk_cur(9'h1B0, 9'h03C);
		rd(legacy_driver_pkg::ADDR_STATUS, d);
		chk(32'(d[0]), 32'h0000_0000, "fullstep flag off");
		@(posedge sys_clk) vel <= 32'hFFFF_FF38;
		get_word();
		chk_cur(fs_a, fs_b);
		wr(legacy_driver_pkg::ADDR_GLOBAL_CONFIG, 32'h0000_0000);
		@(posedge sys_clk) vel <= 32'h0000_0000;
		$display("test fullstep done");
		// Every decay code; code 01 is driven on both the rising and the falling slope
		for (int m = 0; m < 6; m++) begin
			@(posedge sys_clk);
			pos <= (m == 2) ? 8'h00 : 8'h40;
			if (m == 5) vel <= 32'h0000_00C8;
			wr(legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG, (32'(decay_plan[m][3:2]) << 22) | 32'h0000_0008);
			set_cur(cur_a ^ 9'h010, cur_b);
			get_word();
			chk(32'({w.decay_a, w.decay_b}), 32'(decay_plan[m][1:0]), "decay");
		end
		@(posedge sys_clk) vel <= 32'h0000_0000;
		$display("test decay done");
		// Divider keeps the driver clock just under 50 kHz at 20 MHz
		wr(legacy_driver_pkg::ADDR_CHOPPER_DIV, 32'h0000_0192);
		wr(legacy_driver_pkg::ADDR_GLOBAL_CONFIG, 32'h0000_8000);
		count_rises(804, r);
		chk(32'(r), 32'h0000_0002, "divided clock");
		wr(legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG, 32'h00D0_0008);
		count_rises(804, r);
		chk(32'(r), 32'h0000_0004, "doubled clock");
		$display("test clock done");
		// Stall: load 4 is above limit 3, load 3 stops and idles the driver
		flags_cfg <= 8'hA4;
		load_cfg <= 3'h4;
		@(posedge sys_clk) vel <= 32'h0000_00C8;
		wr(legacy_driver_pkg::ADDR_STALL_VEL, 32'h0000_0064);
		wr(legacy_driver_pkg::ADDR_REFERENCE_CONFIG, 32'h0400_0000);
		wr(legacy_driver_pkg::ADDR_DRIVER_LINK_CONFIG, 32'h0020_0349);
		set_cur(cur_a ^ 9'h010, cur_b);
		get_word();
		repeat (6) @(posedge sys_clk);
		#1 chk(32'(ramp_velocity_zero), 32'h0000_0000, "no stall");
		load_cfg <= 3'h3;
		set_cur(cur_a ^ 9'h010, cur_b);
		get_word();
		get_word();
		chk({23'h0, w.idle, w.mag_a, w.mag_b}, 32'h0000_0100, "idle word");
		chk(32'(ramp_velocity_zero), 32'h0000_0001, "stopped");
		rd(legacy_driver_pkg::ADDR_STATUS, d);
		chk({29'h0, d[24], d[2:1]}, 32'h0000_0007, "stall status");
		wr(legacy_driver_pkg::ADDR_REFERENCE_CONFIG, 32'h0C00_0000);
		repeat (2) @(posedge sys_clk);
		#1 chk(32'(ramp_velocity_zero), 32'h0000_0000, "released");
		$display("test stall done");
		tally_and_finish();
	end
endmodule
